// File: rtl/mpm_consts.vh
// constants of the management-bus controller: offsets, fields, resets
// assumes inclusion by bare name from the design files
`ifndef MPM_CONSTS_VH
`define MPM_CONSTS_VH
// register byte offsets (one 32-bit word each)
`define MPM_A_CTRL    8'h00
`define MPM_A_RESP    8'h04
`define MPM_A_LINK    8'h08
`define MPM_A_LRAW    8'h0C
`define MPM_A_LMSK    8'h10
`define MPM_A_DRAW    8'h14
`define MPM_A_DMSK    8'h18
`define MPM_A_MSET    8'h1C
`define MPM_A_MCLR    8'h20
`define MPM_A_UA0     8'h24
`define MPM_A_MS0     8'h28
`define MPM_A_UA1     8'h2C
`define MPM_A_MS1     8'h30
// control register fields
`define MPM_C_EN      30
`define MPM_C_NOPRE   20
`define MPM_C_IDLE    31
`define MPM_DIV_RST   16'h00FF
// access register fields
`define MPM_U_GO      31
`define MPM_U_WR      30
`define MPM_U_ACK     29
`define MPM_U_REG     25:21
`define MPM_U_PHY     20:16
`define MPM_U_DATA    15:0
// monitor select fields
`define MPM_M_IEN     6
`define MPM_M_ADR     4:0
// frame layout: bit index counted from the first preamble bit
`define MPM_PRE_LEN   6'h20
`define MPM_TA0       6'h2E
`define MPM_TA1       6'h2F
`define MPM_LAST      6'h3F
// status register and link bit read by polling
`define MPM_STAT_REG  5'h01
`define MPM_LINK_BIT  2
`endif

// File: rtl/mpm_frame.v
// serial management frame engine: divider, shifter and sampler
// assumes a synchronised data input and one start pulse while not busy
`timescale 1ns/1ps
`default_nettype none
`include "mpm_consts.vh"
module mpm_frame (
  // clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // request
  input  wire        start,
  input  wire        wr,
  input  wire        no_pre,
  input  wire [4:0]  phy,
  input  wire [4:0]  rg,
  input  wire [15:0] wdata,
  input  wire [15:0] div,
  // result
  output reg         busy,
  output reg         done,
  output reg         ack,
  output reg  [15:0] rdata,
  // serial pins
  input  wire        mdi,
  output reg         mdc,
  output wire        mdo,
  output reg         mdo_oe
);
  reg  [63:0] fr_r;
  reg  [5:0]  n_r;
  reg  [15:0] cnt_r;
  reg         wr_r;
  // R6 half period div+1
  wire        tick = (cnt_r == div);
  wire [63:0] frame = {32'hFFFFFFFF, 2'b01, (wr ? 2'b01 : 2'b10),
                       phy, rg, 2'b10, wdata};
  assign mdo = fr_r[63];
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fr_r <= 64'h0; n_r <= 6'h0; cnt_r <= 16'h0000; wr_r <= 1'b0;
      busy <= 1'b0; done <= 1'b0; ack <= 1'b0; rdata <= 16'h0000;
      mdc <= 1'b0; mdo_oe <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy   <= 1'b1;
          wr_r   <= wr;
          ack    <= 1'b0;
          // R8 preamble skip
          fr_r   <= no_pre ? {frame[31:0], 32'h0} : frame;
          n_r    <= no_pre ? `MPM_PRE_LEN : 6'h0;
          cnt_r  <= 16'h0000;
          mdc    <= 1'b0;
          mdo_oe <= 1'b1;
        end
      end else if (!tick) begin
        cnt_r <= cnt_r + 16'h0001;
      end else begin
        cnt_r <= 16'h0000;
        if (!mdc) begin
          mdc <= 1'b1;
        end else begin
          // sampled late in the high half, after synchroniser delay;
          // the four-cycle input delay needs a divisor of at least 2
          mdc <= 1'b0;
          // R17 answer seen as low turnaround bit
          if (!wr_r && n_r == `MPM_TA1)
            ack <= ~mdi;
          if (!wr_r && n_r > `MPM_TA1)
            rdata <= {rdata[14:0], mdi};
          if (n_r == `MPM_LAST) begin
            busy   <= 1'b0;
            done   <= 1'b1;
            mdo_oe <= 1'b0;
          end else begin
            // R21 next frame bit
            n_r  <= n_r + 6'h01;
            fr_r <= {fr_r[62:0], 1'b1};
            if (!wr_r && n_r == `MPM_TA0 - 6'h01)
              mdo_oe <= 1'b0;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/mpm_sync3.v
// three-stage synchroniser for a pin input
// assumes an asynchronous input; output moves once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module mpm_sync3 (
  // clock and reset
  input  wire clk,
  input  wire rst_n,
  // pin and result
  input  wire d,
  output reg  q
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q    <= 1'b1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q <= s3_r;
    end
  end
endmodule
`default_nettype wire

// File: rtl/mpm_top.v
// management-bus controller: register slave, poller, monitor, access queue
// assumes a single-master AHB-Lite bus and PHYs with a pulled-up data wire
//
// Overview of operation
// R1: once enabled, keep polling all 32 PHY addresses with status reads.
// R2: read each address's status register; record responder and link maps.
// R3: set the responder bit of an address whose PHY answers.
// R4: set the link bit only if the PHY answered and has link.
// R5: software reads through access registers also update the responder bit.
// R6: management clock is the system clock divided by a programmed divisor.
// R7: idle until enable is set; enabling also applies divisor and preamble.
// R8: send a preamble by default; software may switch it off.
// R9: monitor link state of two PHYs, addresses from monitor selects.
// R10: a monitored link change sets raw and masked events when enabled.
// R11: a set trigger runs the described read or write unaided.
// R12: on completion clear the trigger and set that register's done bit.
// R13: masked done bits and done interrupt follow the mask set and clear.
// R14: two access registers, served one after another, never overlapped.
// R15: both pending means round-robin choice between them.
// R16: software checks the trigger is clear before writing a new request.
// R17: the acknowledge flag reports whether the PHY answered a read.
// R18: software sets divisor and preamble, enables, then waits and configures.
// R19: a write request is one register write; trigger clear means done.
// R20: after a read, acknowledge is set if answered and data is readable.
// R21: frames follow the clause-22 format shifted on the management clock.
// R22: polling and user frames share the bus one frame at a time.
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mpm_consts.vh"
module mpm_top (
  // clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  // interrupts
  output reg         access_done_irq,
  output reg         link_change_irq,
  // management pins
  output wire        mgmt_clock_pin,
  input  wire        mgmt_data_in,
  output wire        mgmt_data_out,
  output wire        mgmt_data_oe
);
  localparam SRC_POLL = 2'b00;
  localparam SRC_UA0  = 2'b01;
  localparam SRC_UA1  = 2'b10;

  // reset release through two flops
  reg rs1_r;
  reg rst_n;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  // registers
  reg  [31:0] ctrl_r;
  reg         en_r;
  reg         nopre_r;
  reg  [15:0] div_r;
  reg  [31:0] resp_r;
  reg  [31:0] link_r;
  reg  [1:0]  lraw_r;
  reg  [1:0]  draw_r;
  reg  [1:0]  dmask_r;
  reg  [31:0] ua_r [0:1];
  reg  [6:0]  ms_r [0:1];
  reg  [1:0]  mon_r;
  reg  [4:0]  poll_r;
  reg  [1:0]  src_r;
  reg         rr_r;
  reg         start_r;
  reg         wr_r;
  reg  [4:0]  phy_r;
  reg  [4:0]  rg_r;
  reg  [15:0] wd_r;

  // frame engine
  wire        mdi_s;
  wire        f_busy;
  wire        f_done;
  wire        f_ack;
  wire [15:0] f_rd;
  mpm_sync3 u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (mgmt_data_in),
    .q     (mdi_s)
  );
  mpm_frame u_frame (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (start_r),
    .wr     (wr_r),
    .no_pre (nopre_r),
    .phy    (phy_r),
    .rg     (rg_r),
    .wdata  (wd_r),
    // R6 programmed divisor
    .div    (div_r),
    .busy   (f_busy),
    .done   (f_done),
    .ack    (f_ack),
    .rdata  (f_rd),
    .mdi    (mdi_s),
    .mdc    (mgmt_clock_pin),
    .mdo    (mgmt_data_out),
    .mdo_oe (mgmt_data_oe)
  );

  // bus slave: writes land in the data phase, reads take one wait state
  reg        wph_r;
  reg        rph_r;
  reg  [7:0] ad_r;
  wire       take = hsel & htrans[1] & hready;
  wire       wen  = wph_r;
  reg [31:0] rmux;
  always @* begin
    case (ad_r)
      `MPM_A_CTRL: rmux = {~f_busy, ctrl_r[30:0]};
      `MPM_A_RESP: rmux = resp_r;
      `MPM_A_LINK: rmux = link_r;
      `MPM_A_LRAW: rmux = {30'h0, lraw_r};
      `MPM_A_LMSK: rmux = {30'h0, lraw_r & {ms_r[1][`MPM_M_IEN],
                                             ms_r[0][`MPM_M_IEN]}};
      `MPM_A_DRAW: rmux = {30'h0, draw_r};
      `MPM_A_DMSK: rmux = {30'h0, draw_r & dmask_r};
      `MPM_A_MSET: rmux = {30'h0, dmask_r};
      `MPM_A_MCLR: rmux = {30'h0, dmask_r};
      `MPM_A_UA0:  rmux = ua_r[0];
      `MPM_A_MS0:  rmux = {25'h0, ms_r[0]};
      `MPM_A_UA1:  rmux = ua_r[1];
      `MPM_A_MS1:  rmux = {25'h0, ms_r[1]};
      default:     rmux = 32'h00000000;
    endcase
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wph_r <= 1'b0; rph_r <= 1'b0; ad_r <= 8'h00;
      hreadyout <= 1'b1; hrdata <= 32'h00000000; hresp <= 1'b0;
    end else begin
      wph_r <= 1'b0;
      if (rph_r) begin
        hrdata    <= rmux;
        hreadyout <= 1'b1;
        rph_r     <= 1'b0;
      end else if (take) begin
        ad_r  <= haddr[7:0];
        wph_r <= hwrite;
        rph_r <= ~hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  // scheduler and register state
  wire [1:0] pend = {ua_r[1][`MPM_U_GO], ua_r[0][`MPM_U_GO]};
  wire       pick = (pend == 2'b11) ? ~rr_r : pend[1];
  wire       cur_rd = (src_r == SRC_POLL) | ~wr_r;
  wire       ui = (src_r == SRC_UA1);
  wire [1:0] mhit;
  wire [1:0] lset;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_mon
      // R9 monitored addresses
      assign mhit[g] = f_done && src_r == SRC_POLL &&
                       phy_r == ms_r[g][`MPM_M_ADR];
      // R10 change events
      assign lset[g] = mhit[g] && ms_r[g][`MPM_M_IEN] &&
                       (f_ack & f_rd[`MPM_LINK_BIT]) != mon_r[g];
    end
  endgenerate

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= {16'h0000, `MPM_DIV_RST}; en_r <= 1'b0; nopre_r <= 1'b0;
      div_r <= `MPM_DIV_RST; resp_r <= 32'h0; link_r <= 32'h0;
      lraw_r <= 2'b00; draw_r <= 2'b00; dmask_r <= 2'b00;
      ua_r[0] <= 32'h0; ua_r[1] <= 32'h0; ms_r[0] <= 7'h00;
      ms_r[1] <= 7'h00; mon_r <= 2'b00; poll_r <= 5'h00;
      src_r <= SRC_POLL; rr_r <= 1'b0; start_r <= 1'b0; wr_r <= 1'b0;
      phy_r <= 5'h00; rg_r <= 5'h00; wd_r <= 16'h0000;
      access_done_irq <= 1'b0; link_change_irq <= 1'b0;
    end else begin
      start_r <= 1'b0;
      // R13 masked done and interrupt
      access_done_irq <= |(draw_r & dmask_r);
      link_change_irq <= |(lraw_r & {ms_r[1][`MPM_M_IEN],
                                     ms_r[0][`MPM_M_IEN]});
      // software writes; hardware sets below win over clears
      if (wen) begin
        case (ad_r)
          `MPM_A_CTRL: begin
            ctrl_r <= {1'b0, hwdata[30:0]};
            en_r   <= hwdata[`MPM_C_EN];
            // R7 enable applies divisor and preamble
            if (hwdata[`MPM_C_EN]) begin
              div_r   <= hwdata[15:0];
              nopre_r <= hwdata[`MPM_C_NOPRE];
            end
          end
          `MPM_A_LRAW: lraw_r <= lraw_r & ~hwdata[1:0];
          `MPM_A_DRAW: draw_r <= draw_r & ~hwdata[1:0];
          `MPM_A_MSET: dmask_r <= dmask_r | hwdata[1:0];
          `MPM_A_MCLR: dmask_r <= dmask_r & ~hwdata[1:0];
          // a request already in flight is not overwritten
          `MPM_A_UA0: if (!ua_r[0][`MPM_U_GO])
                        ua_r[0] <= hwdata & 32'hDFFFFFFF;
          `MPM_A_UA1: if (!ua_r[1][`MPM_U_GO])
                        ua_r[1] <= hwdata & 32'hDFFFFFFF;
          `MPM_A_MS0: ms_r[0] <= hwdata[6:0];
          `MPM_A_MS1: ms_r[1] <= hwdata[6:0];
          default: ;
        endcase
      end
      // R22 one frame at a time; R14 sequential service
      if (!f_busy && !start_r && !f_done && en_r) begin
        start_r <= 1'b1;
        if (pend != 2'b00) begin
          // R15 round robin; R11 run the request
          src_r <= pick ? SRC_UA1 : SRC_UA0;
          rr_r  <= pick;
          wr_r  <= ua_r[pick][`MPM_U_WR];
          phy_r <= ua_r[pick][`MPM_U_PHY];
          rg_r  <= ua_r[pick][`MPM_U_REG];
          wd_r  <= ua_r[pick][`MPM_U_DATA];
        end else begin
          // R1 poll every address; R2 status register
          src_r  <= SRC_POLL;
          wr_r   <= 1'b0;
          phy_r  <= poll_r;
          rg_r   <= `MPM_STAT_REG;
          poll_r <= poll_r + 5'h01;
        end
      end
      if (f_done) begin
        // R3 responder map; R5 user reads too
        if (cur_rd)
          resp_r[phy_r] <= f_ack;
        // R4 link needs answer and link
        if (src_r == SRC_POLL)
          link_r[phy_r] <= f_ack & f_rd[`MPM_LINK_BIT];
        if (src_r != SRC_POLL) begin
          // R12 clear trigger, set done
          ua_r[ui][`MPM_U_GO] <= 1'b0;
          draw_r[ui] <= 1'b1;
          // R17 R20 acknowledge and data
          if (!wr_r) begin
            ua_r[ui][`MPM_U_ACK]  <= f_ack;
            ua_r[ui][`MPM_U_DATA] <= f_rd;
          end
        end
      end
      if (mhit[0])
        mon_r[0] <= f_ack & f_rd[`MPM_LINK_BIT];
      if (mhit[1])
        mon_r[1] <= f_ack & f_rd[`MPM_LINK_BIT];
      if (lset[0])
        lraw_r[0] <= 1'b1;
      if (lset[1])
        lraw_r[1] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sim/mpm_checker.sv
// checker: bus answer timing and frame shape of the controller
// assumes divisor 2 as the bench sets it; preamble mode follows ctrl writes
`timescale 1ns/1ps
`default_nettype none
`include "mpm_consts.vh"
module mpm_checker (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  // management pins
  input wire logic        mgmt_clock_pin,
  input wire logic        mgmt_data_out,
  input wire logic        mgmt_data_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [6:0] nrise_r;
  logic       ctl_wr_r;
  logic       pre_off_r;
  logic       pre_prev_r;
  logic       fr_nopre_r;
  // rising clock edges seen while the block drives the wire
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
      nrise_r <= 7'h00;
    else if ($rose(mgmt_data_oe))
      nrise_r <= 7'h00;
    else if ($rose(mgmt_clock_pin) && mgmt_data_oe)
      nrise_r <= nrise_r + 7'h01;
  // preamble mode as the engine takes it; a frame keeps its starting mode
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n) begin
      ctl_wr_r   <= 1'b0;
      pre_off_r  <= 1'b0;
      pre_prev_r <= 1'b0;
      fr_nopre_r <= 1'b0;
    end else begin
      ctl_wr_r   <= hsel && htrans[1] && hready && hwrite &&
                    haddr[7:0] == `MPM_A_CTRL;
      pre_prev_r <= pre_off_r;
      if (ctl_wr_r && hwdata[`MPM_C_EN])
        pre_off_r <= hwdata[`MPM_C_NOPRE];
      if ($rose(mgmt_data_oe))
        fr_nopre_r <= pre_prev_r;
    end
  sequence s_rd_ans;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_half;
    mgmt_clock_pin [*3] ##1 !mgmt_clock_pin [*3];
  endsequence
  sequence s_start_code;
    (mgmt_data_oe && !mgmt_data_out) [*6] ##1
      (mgmt_data_oe && mgmt_data_out) [*6];
  endsequence
  property p_wr;
    hsel && htrans[1] && hready && hwrite |=> hreadyout;
  endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
  property p_rd;
    hsel && htrans[1] && hready && !hwrite |=> s_rd_ans;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_div;
    $rose(mgmt_clock_pin) |-> s_half;
  endproperty
  a_div: assert property (p_div) else $error("clock half wrong");
  property p_pre;
    $rose(mgmt_data_oe) && !pre_prev_r |->
      (mgmt_data_oe && mgmt_data_out) [*8];
  endproperty
  a_pre: assert property (p_pre) else $error("no preamble");
  property p_nopre;
    $rose(mgmt_data_oe) && pre_prev_r |-> s_start_code;
  endproperty
  a_nopre: assert property (p_nopre) else $error("no start code");
  property p_start;
    $rose(mgmt_data_oe) |-> !mgmt_clock_pin;
  endproperty
  a_start: assert property (p_start) else $error("bad frame start");
  property p_end;
    $fell(mgmt_data_oe) |-> !mgmt_clock_pin;
  endproperty
  a_end: assert property (p_end) else $error("bad frame end");
  property p_bits;
    $fell(mgmt_data_oe) |-> (fr_nopre_r ?
      (nrise_r == 7'h20 || nrise_r == 7'h0E) :
      (nrise_r == 7'h40 || nrise_r == 7'h2E));
  endproperty
  a_bits: assert property (p_bits) else $error("bit count wrong");
  property p_edge;
    mgmt_data_oe && $past(mgmt_data_oe) && $changed(mgmt_data_out)
      |-> $fell(mgmt_clock_pin);
  endproperty
  a_edge: assert property (p_edge) else $error("data moved late");
endmodule
bind mpm_top mpm_checker u_mpm_checker (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout),
  .mgmt_clock_pin(mgmt_clock_pin), .mgmt_data_out(mgmt_data_out),
  .mgmt_data_oe(mgmt_data_oe)
);
`default_nettype wire

// File: sim/mpm_phy_model.sv
// behavioural population of PHYs sharing the management wire
// assumes a pulled-up data wire; register 1 reports link on bit 2
`timescale 1ns/1ps
`default_nettype none
module mpm_phy_model (
  // population
  input  wire logic [31:0] present,
  input  wire logic [31:0] link_up,
  // pins
  input  wire logic        mdc,
  input  wire logic        mdo,
  input  wire logic        oe,
  output wire logic        mdi
);
  logic [31:0] sr;
  logic [4:0]  cnt = 5'h00;
  logic [4:0]  ph;
  logic [4:0]  rg;
  logic        rd = 1'b0;
  logic        drv_en = 1'b0;
  logic        drv = 1'b1;
  logic [15:0] val;
  logic [15:0] mem [32];
  assign mdi = oe ? mdo : (drv_en ? drv : 1'b1);
  always @(posedge mdc)
    if (cnt != 5'h00 || (oe && !mdo)) begin
      sr = {sr[30:0], mdo};
      if (cnt == 5'h0D) begin
        rd = sr[11:10] == 2'b10;
        ph = sr[9:5];
        rg = sr[4:0];
        val = (rg == 5'h01) ? {13'h0, link_up[ph], 2'h0} : mem[rg];
      end
      if (cnt == 5'h1F && !rd)
        mem[rg] = sr[15:0];
      cnt = cnt + 5'h01;
    end
  always @(negedge mdc) begin
    drv_en = rd && present[ph] && cnt >= 5'h0F;
    drv = (cnt == 5'h0F) ? 1'b0 : val[5'h1F - cnt];
  end
endmodule
`default_nettype wire

// File: sim/tb.sv
// bench: AHB-Lite master, PHY population, random maps and data
// assumes the controller, its checker bind and the PHY model compiled
`timescale 1ns/1ps
`default_nettype none
`include "mpm_consts.vh"
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] pres = 32'h0;
  logic [31:0] lnk = 32'h0;
  logic [31:0] rv;
  logic [4:0]  p, q, r;
  logic [15:0] d;
  logic        act = 1'b0;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  wire         hreadyout, hresp, done_irq, link_irq, mdc, mdi, mdo, oe;
  wire [31:0]  hrdata;
  always #10 clk = ~clk;
  mpm_top u_mpm_top (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .access_done_irq(done_irq), .link_change_irq(link_irq),
    .mgmt_clock_pin(mdc), .mgmt_data_in(mdi), .mgmt_data_out(mdo),
    .mgmt_data_oe(oe)
  );
  mpm_phy_model u_mpm_phy_model (
    .present(pres), .link_up(lnk), .mdc(mdc), .mdo(mdo), .oe(oe),
    .mdi(mdi)
  );
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well above the two sweeps, the waits and the accesses
  always @(posedge clk) begin
    cyc++;
    if (mdc === 1'b1 || oe === 1'b1)
      act <= 1'b1;
    if (cyc == 60000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input [31:0] v);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wait_go(input logic [7:0] a);
    rd(a);
    while (rv[`MPM_U_GO] !== 1'b0)
      rd(a);
  endtask
  function automatic logic [31:0] ua(input logic g, w, k,
                                     input logic [4:0] rr, pp,
                                     input logic [15:0] dd);
    return {g, w, k, 3'h0, rr, pp, dd};
  endfunction
  initial begin
    void'($urandom(32'h9A591181));
    p = 5'($urandom_range(30, 1));
    q = p + 5'h01;
    r = 5'($urandom_range(31, 2));
    d = 16'($urandom);
    pres = $urandom | (32'h1 << p) | (32'h1 << q);
    // address 0 unlinked: slot 0 watches it before p is selected
    lnk = ($urandom | (32'h1 << p) | (32'h1 << q)) & 32'hFFFFFFFE;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (200) @(posedge clk);
    chk("quiet pins", {31'h0, act}, 32'h0); // pins idle
    rd(`MPM_A_CTRL);
    chk("ctrl reset", rv, 32'h800000FF); // reset view
    chk("okay resp", {31'h0, hresp}, 32'h0); // bus answer
    rd(8'h40);
    chk("unmapped", rv, 32'h0); // nothing there
    // divisor and preamble with enable; divisor 2 leaves room
    // for the input synchroniser before the end of the high half
    bus(`MPM_A_CTRL, 1'b1, 32'h40000002);
    repeat (17000) @(posedge clk);
    rd(`MPM_A_RESP);
    chk("responders", rv, pres); // sweep result
    rd(`MPM_A_LINK);
    chk("links", rv, pres & lnk); // link map
    bus(`MPM_A_MS0, 1'b1, {25'h0, 1'b1, 1'b0, p});
    bus(`MPM_A_MS1, 1'b1, {27'h0, q});
    repeat (14000) @(posedge clk);
    rd(`MPM_A_LRAW);
    chk("link raw", rv, 32'h1); // enabled one only
    rd(`MPM_A_LMSK);
    chk("link masked", rv, 32'h1); // masked copy
    chk("link irq", {31'h0, link_irq}, 32'h1); // line up
    bus(`MPM_A_LRAW, 1'b1, 32'h1);
    rd(`MPM_A_LRAW);
    chk("link cleared", rv, 32'h0); // no new change
    bus(`MPM_A_MSET, 1'b1, 32'h1);
    bus(`MPM_A_UA0, 1'b1, ua(1'b1, 1'b1, 1'b0, r, p, d));
    wait_go(`MPM_A_UA0);
    chk("write done", rv, ua(1'b0, 1'b1, 1'b0, r, p, d));
    rd(`MPM_A_DRAW);
    chk("done raw", rv, 32'h1); // matching bit
    rd(`MPM_A_DMSK);
    chk("done masked", rv, 32'h1); // mask set
    chk("done irq", {31'h0, done_irq}, 32'h1); // line up
    bus(`MPM_A_MCLR, 1'b1, 32'h1);
    rd(`MPM_A_DMSK);
    chk("done unmasked", rv, 32'h0); // mask cleared
    chk("irq off", {31'h0, done_irq}, 32'h0); // line down
    bus(`MPM_A_DRAW, 1'b1, 32'h1);
    pres[q] = 1'b0;
    bus(`MPM_A_UA0, 1'b1, ua(1'b1, 1'b0, 1'b0, r, p, 16'h0));
    bus(`MPM_A_UA1, 1'b1, ua(1'b1, 1'b0, 1'b0, r, q, 16'h0));
    wait_go(`MPM_A_UA0);
    chk("read back", rv, ua(1'b0, 1'b0, 1'b1, r, p, d));
    wait_go(`MPM_A_UA1);
    chk("absent ack", {31'h0, rv[`MPM_U_ACK]}, 32'h0); // no answer
    rd(`MPM_A_DRAW);
    chk("both done", rv, 32'h3); // both served
    rd(`MPM_A_RESP);
    chk("responder drop", rv, pres); // user read updates
    // preamble off with the same divisor; enable applies it
    bus(`MPM_A_CTRL, 1'b1, 32'h40100002);
    bus(`MPM_A_UA0, 1'b1, ua(1'b1, 1'b0, 1'b0, r, p, 16'h0));
    wait_go(`MPM_A_UA0);
    chk("short frame", rv, ua(1'b0, 1'b0, 1'b1, r, p, d));
    conclude();
  end
endmodule
`default_nettype wire
